// *** hac_pkg.sv ***
package hac_pkg;
  // register map and field layout of the second allocator control register
  localparam logic [7:0] HAC_CTRL2_IDX     = 8'h51;
  localparam logic [9:0] HAC_CTRL2_ADDR    = {HAC_CTRL2_IDX, 2'b00};
  localparam logic [7:0] HAC_CTRL2_RESET   = 8'h00;
  localparam int         HAC_BIT_RX_EOP    = 7;
  localparam int         HAC_BIT_RESEND_GO_AHEAD_REQ     = 6;
  localparam int         HAC_BIT_TX_EOP    = 5;
  localparam int         HAC_BIT_FIXED_EN  = 4;
  localparam int         HAC_CHAN_MSB      = 3;
  localparam int         HAC_CHAN_W        = 4;
  localparam int         HAC_SLOT_W        = 5;
  localparam int         HAC_ADDR_W        = 12;
  // upper half of the 32 slots of serial_in_stream_one
  localparam logic [4:0] HAC_UPPER_BASE    = 5'h10;
  localparam logic [31:0] HAC_ZERO_WORD    = 32'h0000_0000;
  localparam logic [3:0]  HAC_CHAN_RESET   = 4'h0;

  // word compare of the apb address, byte offset bits ignored
  function automatic logic hac_hit(input logic [11:0] addr, input logic [9:0] target);
    hac_hit = (addr[11:2] == {2'b00, target[9:2]});
  endfunction : hac_hit
endpackage : hac_pkg

// *** hac_slot_map.sv ***
`timescale 1ns/1ps
module hac_slot_map
  import hac_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // selection inputs
  input  wire logic [hac_pkg::HAC_CHAN_W-1:0] channel,
  input  wire logic                  control_first_order,
  // mapped timeslot
  output logic [hac_pkg::HAC_SLOT_W-1:0]      slot
);
  typedef struct packed {
    logic [HAC_SLOT_W-1:0] slot;
  } hac_map_s;

  hac_map_s st;
  hac_map_s next_st;

  // upper half when control precedes data
  always_comb
  begin
    next_st      = st;
    next_st.slot = control_first_order ? (HAC_UPPER_BASE | {1'b0, channel}) : {1'b0, channel};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign slot = st.slot;

  slot_upper_a: assert property (@(posedge clk) disable iff (reset)
    control_first_order && $stable(control_first_order) |=> slot[HAC_SLOT_W-1])
    else $error("upper half not selected");
endmodule : hac_slot_map

// *** hac_ctrl2.sv ***
`timescale 1ns/1ps
// Function
// - eight-bit read/write control register at 0x51, all bits reset to zero
// - bit 7 requests receive packet end; clears once receiver consumes it
// - software receive packet end behaves exactly like hardware packet end
// - bit 6 resends go-ahead with normal timing, then clears itself
// - go-ahead resend honoured only while receiver active, else dropped and cleared
// - bit 5 requests transmit packet end like hardware; clears when consumed
// - bit 4 fixes receive channel, stops go-ahead, ignores auto-hunt flags
// - fixed receive mode holds channel-selected and receiver-active status high
// - bit 4 low uses normal reception with auto-hunt channel choice
// - fixed or preset select makes bits 3-0 choose the receive channel
// - channel picks first or last 16 slots of stream one by ordering bit
// - preset select keeps go-ahead and unforced status; software flag drives receiver
// - ordering bit one puts data channels in slots 16 to 31
module hac_ctrl2
  import hac_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [hac_pkg::HAC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // settings from the first control register
  input  wire logic                        preset_rx_select,
  input  wire logic                        control_first_order,
  input  wire logic                        sw_flag_inject,
  // receive side events and state
  input  wire logic                        hw_rx_packet_end,
  input  wire logic                        rx_eop_taken,
  input  wire logic                        go_ahead_taken,
  input  wire logic                        rx_running,
  input  wire logic                        rx_chan_hunted,
  input  wire logic [hac_pkg::HAC_CHAN_W-1:0] hunt_channel,
  input  wire logic                        hunt_flag,
  input  wire logic                        hunt_go_ahead,
  // transmit side events
  input  wire logic                        hw_tx_packet_end,
  input  wire logic                        tx_eop_taken,
  // outputs toward receive and transmit logic
  output logic                             rx_packet_end,
  output logic                             tx_packet_end,
  output logic                             rx_flag,
  output logic                             go_ahead_req,
  output logic [hac_pkg::HAC_SLOT_W-1:0]   rx_slot,
  output logic                             rx_channel_selected,
  output logic                             rx_active_flag
);
  typedef struct packed {
    logic                  sw_rx_packet_end_req;
    logic                  resend_go_ahead_req;
    logic                  sw_tx_packet_end_req;
    logic                  fixed_rx_select_en;
    logic [HAC_CHAN_W-1:0] fixed_rx_channel;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rx_packet_end;
    logic                  tx_packet_end;
    logic                  rx_flag;
    logic                  go_ahead_req;
    logic                  rx_channel_selected;
    logic                  rx_active_flag;
  } hac_state_s;

  hac_state_s st;
  hac_state_s next_st;

  logic [HAC_CHAN_W-1:0] chan_mux;
  logic                  override;
  logic                  access;
  logic                  hit;
  logic                  wr_any;

  // register image as software sees it, shared by the read path and its checks
  function automatic logic [7:0] hac_ctrl_word(input hac_state_s s);
    hac_ctrl_word = {s.sw_rx_packet_end_req, s.resend_go_ahead_req,
                     s.sw_tx_packet_end_req, s.fixed_rx_select_en,
                     s.fixed_rx_channel};
  endfunction : hac_ctrl_word

  // any write access, mapped or not; lets the checks skip the set-wins cycle
  assign wr_any   = psel & penable & pwrite & ~st.pready;
  assign override = st.fixed_rx_select_en | preset_rx_select;
  assign chan_mux = override ? st.fixed_rx_channel : hunt_channel;
  assign access   = psel & penable & ~st.pready;
  assign hit      = hac_hit(paddr, HAC_CTRL2_ADDR);

  // timeslot mapping kept in its own leaf, one cycle of latency
  hac_slot_map u_slot_map (
    .clk                 (clk),
    .reset               (reset),
    .channel             (chan_mux),
    .control_first_order (control_first_order),
    .slot                (rx_slot)
  );

  // register file, request consumption and outward strobes
  always_comb
  begin
    next_st         = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    // consumption clears first so a fresh write in the same cycle wins
    if (rx_eop_taken)
      next_st.sw_rx_packet_end_req = 1'b0;
    if (tx_eop_taken)
      next_st.sw_tx_packet_end_req = 1'b0;
    if (go_ahead_taken || !(rx_running || st.fixed_rx_select_en) || st.fixed_rx_select_en)
      next_st.resend_go_ahead_req = 1'b0;
    // one wait state: answer lands on the second access edge
    if (access)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~hit;
      next_st.prdata  = HAC_ZERO_WORD;
      if (hit && pwrite)
      begin
        next_st.sw_rx_packet_end_req = pwdata[HAC_BIT_RX_EOP];
        next_st.resend_go_ahead_req  = pwdata[HAC_BIT_RESEND_GO_AHEAD_REQ];
        next_st.sw_tx_packet_end_req = pwdata[HAC_BIT_TX_EOP];
        next_st.fixed_rx_select_en   = pwdata[HAC_BIT_FIXED_EN];
        next_st.fixed_rx_channel     = pwdata[HAC_CHAN_MSB:0];
      end
      else if (hit)
        next_st.prdata[7:0] = hac_ctrl_word(st);
    end
    // software requests merge with hardware indications on the same path
    next_st.rx_packet_end = hw_rx_packet_end | st.sw_rx_packet_end_req;
    next_st.tx_packet_end = hw_tx_packet_end | st.sw_tx_packet_end_req;
    // hunt flags dropped in fixed mode; software flag still reaches receiver
    next_st.rx_flag = (hunt_flag & ~st.fixed_rx_select_en) | sw_flag_inject;
    // go-ahead silenced in fixed mode, kept in preset mode
    next_st.go_ahead_req = ~st.fixed_rx_select_en &
                           (hunt_go_ahead | (st.resend_go_ahead_req & rx_running));
    next_st.rx_channel_selected = st.fixed_rx_select_en | rx_chan_hunted;
    next_st.rx_active_flag      = st.fixed_rx_select_en | rx_running;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st                  <= '0;
      st.fixed_rx_channel <= HAC_CHAN_RESET;
    end
    else
      st <= next_st;
  end

  // outputs straight from state
  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;
  assign rx_packet_end       = st.rx_packet_end;
  assign tx_packet_end       = st.tx_packet_end;
  assign rx_flag             = st.rx_flag;
  assign go_ahead_req        = st.go_ahead_req;
  assign rx_channel_selected = st.rx_channel_selected;
  assign rx_active_flag      = st.rx_active_flag;

  sequence wr_access_s;
    psel && penable && pwrite && !pready && hac_hit(paddr, HAC_CTRL2_ADDR);
  endsequence

  // first access edge of any transfer
  sequence acc_s;
    psel && penable && !pready;
  endsequence

  // the answer is one registered pulse, one wait state after the access edge
  wait_state_a: assert property (@(posedge clk) disable iff (reset)
    acc_s |=> pready)
    else $error("no answer after one wait state");

  // a pulse longer than one cycle would complete the next transfer early
  pready_pulse_a: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  // unmapped addresses answer with an error and zero data
  bad_addr_a: assert property (@(posedge clk) disable iff (reset)
    acc_s ##0 !hit |=> pslverr && prdata == HAC_ZERO_WORD)
    else $error("unmapped access not refused");

  // unmapped writes leave the mode and channel alone
  bad_write_a: assert property (@(posedge clk) disable iff (reset)
    acc_s ##0 (!hit && pwrite) |=> $stable(st.fixed_rx_select_en) && $stable(st.fixed_rx_channel))
    else $error("unmapped write changed the register");

  // full byte read back, upper bits zero
  reg_read_a: assert property (@(posedge clk) disable iff (reset)
    acc_s ##0 (hit && !pwrite) |=> prdata[7:0] == hac_ctrl_word($past(st)))
    else $error("read byte mismatch");

  upper_zero_a: assert property (@(posedge clk) disable iff (reset)
    acc_s ##0 !pwrite |=> prdata[31:8] == HAC_ZERO_WORD[31:8])
    else $error("upper read bits not zero");

  // software requests are taken on the access edge
  rx_set_a: assert property (@(posedge clk) disable iff (reset)
    wr_access_s ##0 pwdata[HAC_BIT_RX_EOP] |=> st.sw_rx_packet_end_req)
    else $error("rx packet end request not stored");

  tx_set_a: assert property (@(posedge clk) disable iff (reset)
    wr_access_s ##0 pwdata[HAC_BIT_TX_EOP] |=> st.sw_tx_packet_end_req)
    else $error("tx packet end request not stored");

  // pending requests wait for their consumer
  rx_hold_a: assert property (@(posedge clk) disable iff (reset)
    st.sw_rx_packet_end_req && !rx_eop_taken && !wr_any |=> st.sw_rx_packet_end_req)
    else $error("rx packet end request dropped early");

  tx_hold_a: assert property (@(posedge clk) disable iff (reset)
    st.sw_tx_packet_end_req && !tx_eop_taken && !wr_any |=> st.sw_tx_packet_end_req)
    else $error("tx packet end request dropped early");

  tx_clear_a: assert property (@(posedge clk) disable iff (reset)
    tx_eop_taken && !wr_any |=> !st.sw_tx_packet_end_req)
    else $error("tx packet end request not cleared");

  // hardware and software ends share one path and one delay
  hw_rx_path_a: assert property (@(posedge clk) disable iff (reset)
    hw_rx_packet_end |=> rx_packet_end)
    else $error("hardware rx packet end not forwarded");

  hw_tx_path_a: assert property (@(posedge clk) disable iff (reset)
    hw_tx_packet_end |=> tx_packet_end)
    else $error("hardware tx packet end not forwarded");

  rx_end_idle_a: assert property (@(posedge clk) disable iff (reset)
    !hw_rx_packet_end && !st.sw_rx_packet_end_req |=> !rx_packet_end)
    else $error("spurious rx packet end");

  // resend is single use
  resend_taken_a: assert property (@(posedge clk) disable iff (reset)
    go_ahead_taken && !wr_any |=> !st.resend_go_ahead_req)
    else $error("resend request not cleared after use");

  // an idle receiver never sees a resent go-ahead
  resend_idle_a: assert property (@(posedge clk) disable iff (reset)
    !rx_running && !hunt_go_ahead |=> !go_ahead_req)
    else $error("go-ahead raised while receiver idle");

  // fixed mode drops any resend request
  fixed_resend_a: assert property (@(posedge clk) disable iff (reset)
    st.fixed_rx_select_en && !wr_any |=> !st.resend_go_ahead_req)
    else $error("resend kept in fixed mode");

  // normal mode passes the receive status through unforced
  normal_status_a: assert property (@(posedge clk) disable iff (reset)
    !st.fixed_rx_select_en
      |=> rx_channel_selected == $past(rx_chan_hunted) && rx_active_flag == $past(rx_running))
    else $error("status forced outside fixed mode");

  hunt_flag_a: assert property (@(posedge clk) disable iff (reset)
    !st.fixed_rx_select_en && hunt_flag |=> rx_flag)
    else $error("hunt flag lost in normal mode");

  hunt_ga_a: assert property (@(posedge clk) disable iff (reset)
    !st.fixed_rx_select_en && hunt_go_ahead |=> go_ahead_req)
    else $error("hunt go-ahead lost in normal mode");

  // preset select leaves the active status to the receiver
  preset_status_a: assert property (@(posedge clk) disable iff (reset)
    preset_rx_select && !st.fixed_rx_select_en && !rx_running |=> !rx_active_flag)
    else $error("preset mode forced receiver active");

  sw_flag_a: assert property (@(posedge clk) disable iff (reset)
    sw_flag_inject |=> rx_flag)
    else $error("software flag not forwarded");

  // programmed channel lands in the upper half when control leads
  preset_chan_a: assert property (@(posedge clk) disable iff (reset)
    override && control_first_order
      |=> rx_slot == (HAC_UPPER_BASE | {1'b0, $past(st.fixed_rx_channel)}))
    else $error("programmed channel not in upper half");

  slot_lower_a: assert property (@(posedge clk) disable iff (reset)
    !control_first_order |=> !rx_slot[HAC_SLOT_W-1])
    else $error("lower half not selected");

  reg_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_access_s ##0 (pwdata[HAC_BIT_FIXED_EN]) |=> st.fixed_rx_select_en)
    else $error("fixed enable write lost");

  rx_clear_a: assert property (@(posedge clk) disable iff (reset)
    rx_eop_taken && !(psel && penable && pwrite && !pready) |=> !st.sw_rx_packet_end_req)
    else $error("rx packet end request not cleared");

  rx_merge_a: assert property (@(posedge clk) disable iff (reset)
    st.sw_rx_packet_end_req |=> rx_packet_end)
    else $error("software rx packet end not forwarded");

  resend_drop_a: assert property (@(posedge clk) disable iff (reset)
    !rx_running && !(psel && penable && pwrite && !pready) |=> !st.resend_go_ahead_req)
    else $error("resend kept while receiver idle");

  resend_fire_a: assert property (@(posedge clk) disable iff (reset)
    st.resend_go_ahead_req && rx_running && !st.fixed_rx_select_en |=> go_ahead_req)
    else $error("resend did not raise go-ahead");

  tx_merge_a: assert property (@(posedge clk) disable iff (reset)
    st.sw_tx_packet_end_req |=> tx_packet_end)
    else $error("software tx packet end not forwarded");

  fixed_quiet_a: assert property (@(posedge clk) disable iff (reset)
    st.fixed_rx_select_en && !sw_flag_inject |=> !go_ahead_req && !rx_flag)
    else $error("fixed mode leaked go-ahead or hunt flag");

  fixed_status_a: assert property (@(posedge clk) disable iff (reset)
    st.fixed_rx_select_en |=> rx_channel_selected && rx_active_flag)
    else $error("fixed mode status not held high");

  hunt_chan_a: assert property (@(posedge clk) disable iff (reset)
    !override && !control_first_order && $stable(hunt_channel)
      |=> rx_slot == {1'b0, $past(hunt_channel)})
    else $error("hunted channel not used");

  fixed_chan_a: assert property (@(posedge clk) disable iff (reset)
    override && !control_first_order |=> rx_slot[HAC_CHAN_W-1:0] == $past(st.fixed_rx_channel))
    else $error("programmed channel not used");

  preset_ga_a: assert property (@(posedge clk) disable iff (reset)
    preset_rx_select && !st.fixed_rx_select_en && hunt_go_ahead |=> go_ahead_req)
    else $error("preset mode blocked go-ahead");

  read_back_a: assert property (@(posedge clk) disable iff (reset)
    psel && penable && !pwrite && !pready && hit
      |=> pready && prdata[HAC_BIT_FIXED_EN] == $past(st.fixed_rx_select_en))
    else $error("read back mismatch");
endmodule : hac_ctrl2

// *** hac_ctrl2_tb.sv ***
`timescale 1ns/1ps
module hac_ctrl2_tb;
  import hac_pkg::*;
  // clock, reset and apb master side
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  // neighbour logic driven by the bench
  logic preset_rx_select = 1'b0, control_first_order = 1'b0, sw_flag_inject = 1'b0, hw_rx_packet_end = 1'b0;
  logic rx_eop_taken = 1'b0, go_ahead_taken = 1'b0, rx_running = 1'b0, rx_chan_hunted = 1'b0;
  logic hunt_flag = 1'b0, hunt_go_ahead = 1'b0, hw_tx_packet_end = 1'b0, tx_eop_taken = 1'b0;
  logic [3:0] hunt_channel = 4'h3;
  wire logic rx_packet_end, tx_packet_end, rx_flag, go_ahead_req, rx_channel_selected, rx_active_flag;
  wire logic [4:0] rx_slot;
  int failures = 0, check_count = 0, cycles = 0;
  localparam logic [11:0] reg_addr = {2'b00, HAC_CTRL2_ADDR};
  localparam logic [11:0] bad_addr = 12'h148;

  hac_ctrl2 hac_ctrl2_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .preset_rx_select(preset_rx_select), .control_first_order(control_first_order),
    .sw_flag_inject(sw_flag_inject), .hw_rx_packet_end(hw_rx_packet_end), .rx_eop_taken(rx_eop_taken),
    .go_ahead_taken(go_ahead_taken), .rx_running(rx_running), .rx_chan_hunted(rx_chan_hunted),
    .hunt_channel(hunt_channel), .hunt_flag(hunt_flag), .hunt_go_ahead(hunt_go_ahead),
    .hw_tx_packet_end(hw_tx_packet_end), .tx_eop_taken(tx_eop_taken), .rx_packet_end(rx_packet_end),
    .tx_packet_end(tx_packet_end), .rx_flag(rx_flag), .go_ahead_req(go_ahead_req), .rx_slot(rx_slot),
    .rx_channel_selected(rx_channel_selected), .rx_active_flag(rx_active_flag));

  // 250 MHz clock
  always #2 clk = ~clk;

  // hang guard, far above the hundred or so cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one apb transfer; waits for pready rather than assuming the wait state
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e,
                     input logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // look between edges, where pready and prdata are settled
    do
    begin
      @(negedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    check("pready", 1, 32'(pready));
    check("pslverr", 32'(err), 32'(pslverr));
    if (!wr)
      check("prdata", {24'h0, e}, prdata);
    // the transfer completes at the edge that samples pready high
    @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // registered outputs get a few edges to follow their causes
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    apb(0, reg_addr, 0, 8'h00, 0);
    apb(1, bad_addr, 8'hff, 0, 1);
    apb(0, bad_addr, 0, 8'h00, 1);
    apb(0, reg_addr, 0, 8'h00, 0);
    // software packet ends stay pending until the consumer takes them
    apb(1, reg_addr, 8'ha0, 0, 0);
    settle();
    check("rx_packet_end", 1, 32'(rx_packet_end));
    check("tx_packet_end", 1, 32'(tx_packet_end));
    apb(0, reg_addr, 0, 8'ha0, 0);
    rx_eop_taken <= 1'b1;
    @(posedge clk);
    rx_eop_taken <= 1'b0;
    settle();
    apb(0, reg_addr, 0, 8'h20, 0);
    check("rx_packet_end", 0, 32'(rx_packet_end));
    tx_eop_taken <= 1'b1;
    @(posedge clk);
    tx_eop_taken <= 1'b0;
    settle();
    apb(0, reg_addr, 0, 8'h00, 0);
    check("tx_packet_end", 0, 32'(tx_packet_end));
    // hardware packet ends reach the same outputs
    hw_rx_packet_end <= 1'b1;
    hw_tx_packet_end <= 1'b1;
    settle();
    check("rx_packet_end", 1, 32'(rx_packet_end));
    check("tx_packet_end", 1, 32'(tx_packet_end));
    hw_rx_packet_end <= 1'b0;
    hw_tx_packet_end <= 1'b0;
    // go-ahead resend dropped while the receiver is idle
    apb(1, reg_addr, 8'h40, 0, 0);
    settle();
    check("go_ahead_req", 0, 32'(go_ahead_req));
    apb(0, reg_addr, 0, 8'h00, 0);
    rx_running <= 1'b1;
    apb(1, reg_addr, 8'h40, 0, 0);
    settle();
    check("go_ahead_req", 1, 32'(go_ahead_req));
    apb(0, reg_addr, 0, 8'h40, 0);
    go_ahead_taken <= 1'b1;
    @(posedge clk);
    go_ahead_taken <= 1'b0;
    settle();
    apb(0, reg_addr, 0, 8'h00, 0);
    // dedicated channel 10 with hunt activity and an idle receiver
    rx_running    <= 1'b0;
    hunt_flag     <= 1'b1;
    hunt_go_ahead <= 1'b1;
    apb(1, reg_addr, 8'h1a, 0, 0);
    settle();
    check("rx_channel_selected", 1, 32'(rx_channel_selected));
    check("rx_active_flag", 1, 32'(rx_active_flag));
    check("rx_flag", 0, 32'(rx_flag));
    check("go_ahead_req", 0, 32'(go_ahead_req));
    check("rx_slot", 32'h0a, 32'(rx_slot));
    control_first_order <= 1'b1;
    settle();
    check("rx_slot", 32'(HAC_UPPER_BASE | 5'h0a), 32'(rx_slot));
    // preset select: channel from the register, nothing forced
    preset_rx_select <= 1'b1;
    hunt_flag        <= 1'b0;
    sw_flag_inject   <= 1'b1;
    apb(1, reg_addr, 8'h05, 0, 0);
    settle();
    check("rx_slot", 32'(HAC_UPPER_BASE | 5'h05), 32'(rx_slot));
    check("go_ahead_req", 1, 32'(go_ahead_req));
    check("rx_active_flag", 0, 32'(rx_active_flag));
    check("rx_flag", 1, 32'(rx_flag));
    // plain multiplexed reception follows the hunt result
    preset_rx_select    <= 1'b0;
    control_first_order <= 1'b0;
    rx_chan_hunted      <= 1'b1;
    settle();
    check("rx_slot", 32'h03, 32'(rx_slot));
    check("rx_channel_selected", 1, 32'(rx_channel_selected));
    finish_test();
  end
endmodule : hac_ctrl2_tb
